//--- hw/aclink_rx_top.sv
// AC-link receive path with the audio controller register file
// Operation
// - Tag bits 3..6 flag slots 1..4 as holding valid data.
// - Status address bits 18..12 echo the register address last requested.
// - Status address bit 11 requests left playback data; zero without variable rate.
// - Status address bit 10 requests right playback data, same zero condition.
// - Slot 3 carries left record sample in bits 19..4, low nibble zero.
// - Slot 4 carries right record sample in bits 19..4, low nibble zero.
// - Record base and length registers are writable and reset to zero.
// - Play base and length registers are writable and reset to zero.
// - Current record and play addresses are read-only, hardware updated, reset zero.
// - Slots are twenty bits; tag plus four used slots per frame.
// - Link works only while main control enable bit 1 is set.
`timescale 1ns/100ps
module aclink_rx_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic bit_clk_i,
  input wire logic sync_i,
  input wire logic sdata_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic [15:0] rec_left_o,
  output logic [15:0] rec_right_o,
  output logic rec_valid_o,
  output logic play_req_left_o,
  output logic play_req_right_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] main_ctrl;
    logic [31:0] sub_rst;
    logic [31:0] rec_base;
    logic [31:0] rec_len;
    logic [31:0] rec_off;
    logic [31:0] rec_stat;
    logic [31:0] play_base;
    logic [31:0] play_len;
    logic [31:0] play_off;
    logic [31:0] play_stat;
    logic [31:0] i2s_ctrl;
    logic [31:0] acl_ctrl;
    logic [31:0] tx0;
    logic [31:0] tx1;
    logic [31:0] tx2;
    logic [31:0] rx0;
    logic [31:0] rx1;
    logic [31:0] rx2;
    logic [31:0] rdata;
    logic ack;
    logic [15:0] rec_l;
    logic [15:0] rec_r;
    logic rec_v;
    logic req_l;
    logic req_r;
    logic tog_seen;
  } top_t;

  top_t q;
  top_t n;

  logic link_en;
  logic link_tog;
  logic tog_sync;
  logic [15:0] link_tag;
  logic [19:0] link_s1;
  logic [19:0] link_s2;
  logic [19:0] link_s3;
  logic [19:0] link_s4;
  logic frame_new;
  logic fvalid;
  logic wr_rec_base;
  logic wr_play_base;

  // ----------------------------------------------------------------
  // Link domain and crossings
  // ----------------------------------------------------------------
  bit_sync en_sync (
    .clk_i(bit_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(q.main_ctrl[aclink_rx_pkg::CON_ACLINK_EN]),
    .q_o(link_en)
  );

  aclink_rx_link link (
    .bit_clk_i(bit_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(link_en),
    .sync_i(sync_i),
    .sdata_i(sdata_i),
    .frame_tog_o(link_tog),
    .tag_o(link_tag),
    .slot1_o(link_s1),
    .slot2_o(link_s2),
    .slot3_o(link_s3),
    .slot4_o(link_s4)
  );

  bit_sync tog_sync_inst (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(link_tog),
    .q_o(tog_sync)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_off(input logic [31:0] off, input logic [31:0] len);
    logic [31:0] sum;
    sum = off + aclink_rx_pkg::ADDR_STEP;
    if (sum >= len) begin
      next_off = aclink_rx_pkg::RST_ZERO;
    end else begin
      next_off = sum;
    end
  endfunction

  function automatic logic [31:0] read_word(input top_t s, input logic [31:0] a);
    case (a)
      aclink_rx_pkg::ADDR_MAIN_CTRL: read_word = s.main_ctrl;
      aclink_rx_pkg::ADDR_SUB_RST: read_word = s.sub_rst;
      aclink_rx_pkg::ADDR_REC_BASE: read_word = s.rec_base;
      aclink_rx_pkg::ADDR_REC_LEN: read_word = s.rec_len;
      aclink_rx_pkg::ADDR_REC_CUR: read_word = s.rec_base + s.rec_off;
      aclink_rx_pkg::ADDR_REC_STAT: read_word = s.rec_stat;
      aclink_rx_pkg::ADDR_PLAY_BASE: read_word = s.play_base;
      aclink_rx_pkg::ADDR_PLAY_LEN: read_word = s.play_len;
      aclink_rx_pkg::ADDR_PLAY_CUR: read_word = s.play_base + s.play_off;
      aclink_rx_pkg::ADDR_PLAY_STAT: read_word = s.play_stat;
      aclink_rx_pkg::ADDR_I2S_CTRL: read_word = s.i2s_ctrl;
      aclink_rx_pkg::ADDR_ACL_CTRL: read_word = s.acl_ctrl;
      aclink_rx_pkg::ADDR_TX_SLOT0: read_word = s.tx0;
      aclink_rx_pkg::ADDR_TX_SLOT1: read_word = s.tx1;
      aclink_rx_pkg::ADDR_TX_SLOT2: read_word = s.tx2;
      aclink_rx_pkg::ADDR_RX_SLOT0: read_word = s.rx0;
      aclink_rx_pkg::ADDR_RX_SLOT1: read_word = s.rx1;
      aclink_rx_pkg::ADDR_RX_SLOT2: read_word = s.rx2;
      default: read_word = aclink_rx_pkg::RST_ZERO;
    endcase
  endfunction

  assign frame_new = tog_sync != q.tog_seen;
  assign fvalid = link_tag[aclink_rx_pkg::TAG_FRAME_VALID];
  assign wr_rec_base = reg_sel_i && reg_wr_i && reg_addr_i == aclink_rx_pkg::ADDR_REC_BASE;
  assign wr_play_base = reg_sel_i && reg_wr_i && reg_addr_i == aclink_rx_pkg::ADDR_PLAY_BASE;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    n.ack = 1'b0;
    n.rec_v = 1'b0;
    n.req_l = 1'b0;
    n.req_r = 1'b0;
    n.tog_seen = tog_sync;
    // Frames arriving while disabled are dropped
    if (frame_new && q.main_ctrl[aclink_rx_pkg::CON_ACLINK_EN]) begin
      n.rx0 = {16'h0000, link_tag};
      if (fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID]) begin
        n.rx1 = {12'h000, link_s1};
      end
      if (fvalid && link_tag[aclink_rx_pkg::TAG_SLOT2_VALID]) begin
        n.rx2 = {12'h000, link_s2};
      end
      if (fvalid && link_tag[aclink_rx_pkg::TAG_SLOT3_VALID]) begin
        n.rec_l = link_s3[aclink_rx_pkg::PCM_HI:aclink_rx_pkg::PCM_LO];
      end
      if (fvalid && link_tag[aclink_rx_pkg::TAG_SLOT4_VALID]) begin
        n.rec_r = link_s4[aclink_rx_pkg::PCM_HI:aclink_rx_pkg::PCM_LO];
      end
      n.rec_v = fvalid && (link_tag[aclink_rx_pkg::TAG_SLOT3_VALID] ||
                           link_tag[aclink_rx_pkg::TAG_SLOT4_VALID]);
      // Without variable rate every valid frame asks for play data
      if (q.acl_ctrl[aclink_rx_pkg::ACL_VRA]) begin
        n.req_l = fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID] &&
                  link_s1[aclink_rx_pkg::REQ_LEFT];
        n.req_r = fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID] &&
                  link_s1[aclink_rx_pkg::REQ_RIGHT];
      end else begin
        n.req_l = fvalid;
        n.req_r = fvalid;
      end
      if (n.rec_v) begin
        n.rec_off = next_off(q.rec_off, q.rec_len);
      end
      if (n.req_l || n.req_r) begin
        n.play_off = next_off(q.play_off, q.play_len);
      end
    end
    // Register writes; current addresses are not writable
    if (reg_sel_i && reg_wr_i) begin
      case (reg_addr_i)
        aclink_rx_pkg::ADDR_MAIN_CTRL: n.main_ctrl = reg_wdata_i;
        aclink_rx_pkg::ADDR_SUB_RST: n.sub_rst = reg_wdata_i;
        aclink_rx_pkg::ADDR_REC_BASE: begin
          n.rec_base = reg_wdata_i;
          n.rec_off = aclink_rx_pkg::RST_ZERO;
        end
        aclink_rx_pkg::ADDR_REC_LEN: n.rec_len = reg_wdata_i;
        aclink_rx_pkg::ADDR_REC_STAT: n.rec_stat = reg_wdata_i;
        aclink_rx_pkg::ADDR_PLAY_BASE: begin
          n.play_base = reg_wdata_i;
          n.play_off = aclink_rx_pkg::RST_ZERO;
        end
        aclink_rx_pkg::ADDR_PLAY_LEN: n.play_len = reg_wdata_i;
        aclink_rx_pkg::ADDR_PLAY_STAT: n.play_stat = reg_wdata_i;
        aclink_rx_pkg::ADDR_I2S_CTRL: n.i2s_ctrl = reg_wdata_i;
        aclink_rx_pkg::ADDR_ACL_CTRL: n.acl_ctrl = reg_wdata_i;
        aclink_rx_pkg::ADDR_TX_SLOT0: n.tx0 = reg_wdata_i;
        aclink_rx_pkg::ADDR_TX_SLOT1: n.tx1 = reg_wdata_i;
        aclink_rx_pkg::ADDR_TX_SLOT2: n.tx2 = reg_wdata_i;
        default: n.ack = 1'b0;
      endcase
    end
    // Every access is answered one cycle later
    if (reg_sel_i) begin
      n.ack = 1'b1;
      n.rdata = reg_wr_i ? aclink_rx_pkg::RST_ZERO : read_word(q, reg_addr_i);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.play_stat <= aclink_rx_pkg::RST_PLAY_STAT;
      q.tx1 <= aclink_rx_pkg::RST_TX_SLOT1;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = q.rdata;
  assign reg_ack_o = q.ack;
  assign rec_left_o = q.rec_l;
  assign rec_right_o = q.rec_r;
  assign rec_valid_o = q.rec_v;
  assign play_req_left_o = q.req_l;
  assign play_req_right_o = q.req_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic en_now;
  logic take;
  assign en_now = q.main_ctrl[aclink_rx_pkg::CON_ACLINK_EN];
  assign take = frame_new && en_now;

  sequence reg_wr_rd_s(logic [31:0] a);
    (reg_sel_i && reg_wr_i && reg_addr_i == a) ##1
    (reg_sel_i && !reg_wr_i && reg_addr_i == a);
  endsequence

  rec_len_rw_a: assert property (
    reg_wr_rd_s(aclink_rx_pkg::ADDR_REC_LEN) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("record length readback mismatch");

  play_len_rw_a: assert property (
    reg_wr_rd_s(aclink_rx_pkg::ADDR_PLAY_LEN) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("play length readback mismatch");

  rec_cur_hw_a: assert property (
    $changed(q.rec_off) |-> q.rec_v || $past(wr_rec_base))
    else $error("record current moved without sample or base write");

  play_cur_hw_a: assert property (
    $changed(q.play_off) |-> q.req_l || q.req_r || $past(wr_play_base))
    else $error("play current moved without request or base write");

  tag_latch_a: assert property (
    take |=> q.rx0[15:0] == $past(link_tag))
    else $error("tag not latched at frame end");

  slot1_gate_a: assert property (
    take && !(fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID]) |=> $stable(q.rx1))
    else $error("invalid slot 1 was latched");

  addr_echo_a: assert property (
    take && fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID]
    |=> q.rx1[18:12] == $past(link_s1[18:12]))
    else $error("address echo not captured");

  left_req_a: assert property (
    take && q.acl_ctrl[aclink_rx_pkg::ACL_VRA]
    |=> play_req_left_o == $past(fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID] &&
                                  link_s1[aclink_rx_pkg::REQ_LEFT]))
    else $error("left play request wrong");

  right_req_a: assert property (
    take && q.acl_ctrl[aclink_rx_pkg::ACL_VRA]
    |=> play_req_right_o == $past(fvalid && link_tag[aclink_rx_pkg::TAG_SLOT1_VALID] &&
                                   link_s1[aclink_rx_pkg::REQ_RIGHT]))
    else $error("right play request wrong");

  left_rec_a: assert property (
    take && fvalid && link_tag[aclink_rx_pkg::TAG_SLOT3_VALID]
    |=> rec_valid_o && rec_left_o == $past(link_s3[19:4]))
    else $error("left record sample wrong");

  right_rec_a: assert property (
    take && fvalid && link_tag[aclink_rx_pkg::TAG_SLOT4_VALID]
    |=> rec_valid_o && rec_right_o == $past(link_s4[19:4]))
    else $error("right record sample wrong");

  disabled_quiet_a: assert property (
    !en_now |=> !rec_valid_o && !play_req_left_o && !play_req_right_o)
    else $error("activity while link disabled");

  rec_cur_ro_a: assert property (
    reg_sel_i && reg_wr_i && reg_addr_i == aclink_rx_pkg::ADDR_REC_CUR && !take
    |=> $stable(q.rec_base) && $stable(q.rec_off))
    else $error("write moved the record current address");

  slot2_gate_a: assert property (
    take && !(fvalid && link_tag[aclink_rx_pkg::TAG_SLOT2_VALID]) |=> $stable(q.rx2))
    else $error("invalid slot 2 was latched");

  fixed_rate_req_a: assert property (
    take && !q.acl_ctrl[aclink_rx_pkg::ACL_VRA]
    |=> play_req_left_o == $past(fvalid) && play_req_right_o == $past(fvalid))
    else $error("fixed rate play request wrong");

  rec_hold_a: assert property (
    take && !(fvalid && link_tag[aclink_rx_pkg::TAG_SLOT3_VALID])
    |=> $stable(rec_left_o))
    else $error("left record sample moved without a valid slot");

  reg_ack_a: assert property (
    reg_ack_o == $past(reg_sel_i))
    else $error("register answer not one cycle after request");
endmodule

//--- hw/aclink_rx_pkg.sv
// Constants for the AC-link receive block and its register map
package aclink_rx_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_MAIN_CTRL = 32'hFFF0_9000;
  localparam logic [31:0] ADDR_SUB_RST = 32'hFFF0_9004;
  localparam logic [31:0] ADDR_REC_BASE = 32'hFFF0_9008;
  localparam logic [31:0] ADDR_REC_LEN = 32'hFFF0_900C;
  localparam logic [31:0] ADDR_REC_CUR = 32'hFFF0_9010;
  localparam logic [31:0] ADDR_REC_STAT = 32'hFFF0_9014;
  localparam logic [31:0] ADDR_PLAY_BASE = 32'hFFF0_9018;
  localparam logic [31:0] ADDR_PLAY_LEN = 32'hFFF0_901C;
  localparam logic [31:0] ADDR_PLAY_CUR = 32'hFFF0_9020;
  localparam logic [31:0] ADDR_PLAY_STAT = 32'hFFF0_9024;
  localparam logic [31:0] ADDR_I2S_CTRL = 32'hFFF0_9028;
  localparam logic [31:0] ADDR_ACL_CTRL = 32'hFFF0_902C;
  localparam logic [31:0] ADDR_TX_SLOT0 = 32'hFFF0_9030;
  localparam logic [31:0] ADDR_TX_SLOT1 = 32'hFFF0_9034;
  localparam logic [31:0] ADDR_TX_SLOT2 = 32'hFFF0_9038;
  localparam logic [31:0] ADDR_RX_SLOT0 = 32'hFFF0_903C;
  localparam logic [31:0] ADDR_RX_SLOT1 = 32'hFFF0_9040;
  localparam logic [31:0] ADDR_RX_SLOT2 = 32'hFFF0_9044;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_PLAY_STAT = 32'h0000_0004;
  localparam logic [31:0] RST_TX_SLOT1 = 32'h0000_0080;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int TAG_BITS = 16;
  localparam int SLOT_BITS = 20;
  localparam int USED_SLOTS = 4;
  localparam logic [6:0] FRAME_LAST = 7'h5F;
  localparam int TAG_FRAME_VALID = 15;
  localparam int TAG_SLOT1_VALID = 3;
  localparam int TAG_SLOT2_VALID = 4;
  localparam int TAG_SLOT3_VALID = 5;
  localparam int TAG_SLOT4_VALID = 6;
  localparam int REQ_LEFT = 11;
  localparam int REQ_RIGHT = 10;
  localparam int PCM_HI = 19;
  localparam int PCM_LO = 4;

  // ----------------------------------------------------------------
  // Control fields and address step
  // ----------------------------------------------------------------
  localparam int CON_ACLINK_EN = 1;
  localparam int ACL_VRA = 0;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
endpackage

//--- hw/bit_sync.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
module bit_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_t;

  sync_t q;
  sync_t n;

  always_comb begin
    n = q;
    n.meta = d_i;
    n.stable = q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign q_o = q.stable;
endmodule

//--- hw/aclink_rx_link.sv
// Serial frame deserialiser on the link bit clock
`timescale 1ns/100ps
module aclink_rx_link (
  input wire logic bit_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic sync_i,
  input wire logic sdata_i,
  output logic frame_tog_o,
  output logic [15:0] tag_o,
  output logic [19:0] slot1_o,
  output logic [19:0] slot2_o,
  output logic [19:0] slot3_o,
  output logic [19:0] slot4_o
);
  typedef struct packed {
    logic active;
    logic sync_q;
    logic [6:0] cnt;
    logic [19:0] shift;
    logic [15:0] tag;
    logic [19:0] s1;
    logic [19:0] s2;
    logic [19:0] s3;
    logic [19:0] s4;
    logic tog;
  } link_t;

  link_t q;
  link_t n;
  logic [19:0] word;

  always_comb begin
    n = q;
    word = {q.shift[18:0], sdata_i};
    n.sync_q = sync_i;
    n.shift = word;
    if (!enable_i) begin
      n.active = 1'b0;
    end else if (sync_i && !q.sync_q) begin
      n.active = 1'b1;
      n.cnt = 7'h01;
    end else if (q.active) begin
      n.cnt = q.cnt + 7'h01;
      // Tag is 16 bits, then four 20-bit slots
      case (q.cnt)
        7'h0F: n.tag = word[15:0];
        7'h23: n.s1 = word;
        7'h37: n.s2 = word;
        7'h4B: n.s3 = word;
        aclink_rx_pkg::FRAME_LAST: begin
          n.s4 = word;
          n.tog = ~q.tog;
          n.active = 1'b0;
        end
        default: n.cnt = q.cnt + 7'h01;
      endcase
    end
  end

  always_ff @(posedge bit_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign frame_tog_o = q.tog;
  assign tag_o = q.tag;
  assign slot1_o = q.s1;
  assign slot2_o = q.s2;
  assign slot3_o = q.s3;
  assign slot4_o = q.s4;

  frame_length_a: assert property (@(posedge bit_clk_i) disable iff (!rst_n_i || !enable_i)
    (sync_i && !q.sync_q && !q.active) |-> ##96 (q.tog != $past(q.tog)))
    else $error("frame did not complete after 96 bits");
endmodule

//--- tb/codec_model.sv
// Behavioural codec driving the serial receive link
`timescale 1ns/100ps
module codec_model (
  output logic bit_clk_o,
  output logic sync_o,
  output logic sdata_o
);
  initial begin
    bit_clk_o = 1'b0;
    sync_o = 1'b0;
    sdata_o = 1'b1;
  end

  // One bit period; lines change while the clock is low
  task automatic edge_out(input logic s, input logic d);
    sync_o = s;
    sdata_o = d;
    #80 bit_clk_o = 1'b1;
    #80 bit_clk_o = 1'b0;
  endtask

  // Idle edges; data line toggles so no stale level looks valid
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      edge_out(1'b0, ~sdata_o);
    end
  endtask

  // Tag then four slots, MSB first; four idle clocks before and six after
  task automatic send_frame(input logic [15:0] tag, input logic [19:0] s1,
                            input logic [19:0] s2, input logic [19:0] s3,
                            input logic [19:0] s4);
    logic [95:0] bits;
    bits = {tag, s1, s2, s3, s4};
    #3.7;
    idle(4);
    for (int i = 0; i < 96; i++) begin
      edge_out(i < 16, bits[95-i]);
    end
    idle(6);
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the receive link and its registers
`timescale 1ns/100ps
module tb;
  logic mclk_i, rst_n_i, reg_sel_i, reg_wr_i, reg_ack_o, rec_valid_o;
  logic play_req_left_o, play_req_right_o, bit_clk, sync, sdata;
  logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
  logic [15:0] rec_left_o, rec_right_o;
  int fail_count, n_checks, n_rv, n_pl, n_pr;
  typedef struct packed {logic [31:0] addr; logic [31:0] wdata; logic [31:0] exp;} row_t;
  row_t rows [9];

  codec_model codec (.bit_clk_o(bit_clk), .sync_o(sync), .sdata_o(sdata));
  aclink_rx_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bit_clk_i(bit_clk),
    .sync_i(sync), .sdata_i(sdata), .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .rec_left_o(rec_left_o), .rec_right_o(rec_right_o),
    .rec_valid_o(rec_valid_o), .play_req_left_o(play_req_left_o),
    .play_req_right_o(play_req_right_o));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Pulse counters, one count per high cycle
  always @(posedge mclk_i) begin
    if (rec_valid_o === 1'b1) n_rv++;
    if (play_req_left_o === 1'b1) n_pl++;
    if (play_req_right_o === 1'b1) n_pr++;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // One register access; answer sampled 1 ns after the take edge
  task automatic reg_op(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge mclk_i);
    reg_sel_i <= 1'b1;
    reg_wr_i <= wr;
    reg_addr_i <= addr;
    reg_wdata_i <= wdata;
    @(posedge mclk_i);
    reg_sel_i <= 1'b0;
    #1;
    check("reg_ack", 32'h0000_0001, {31'h0, reg_ack_o});
    rd = reg_rdata_o;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] addr, input logic [31:0] exp);
    reg_op(1'b0, addr, 32'h0000_0000);
    check(what, exp, rd);
  endtask

  // Write then read in the next cycle; read answer one cycle after the read
  task automatic b2b(input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge mclk_i);
    reg_sel_i <= 1'b1;
    reg_wr_i <= 1'b1;
    reg_addr_i <= addr;
    reg_wdata_i <= wdata;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
    reg_sel_i <= 1'b0;
    #1;
    check("b2b ack", 32'h0000_0001, {31'h0, reg_ack_o});
    check("b2b readback", wdata, reg_rdata_o);
  endtask

  task automatic frame(input logic [15:0] tag, input logic [19:0] s1, input logic [19:0] s2,
                       input logic [19:0] s3, input logic [19:0] s4, input logic [31:0] e0,
                       input logic [31:0] e1, input logic [31:0] e2, input logic [15:0] el,
                       input logic [15:0] er, input int nv, input int npl, input int npr);
    n_rv = 0;
    n_pl = 0;
    n_pr = 0;
    codec.send_frame(tag, s1, s2, s3, s4);
    rd_chk("rx_slot0", aclink_rx_pkg::ADDR_RX_SLOT0, e0);
    rd_chk("rx_slot1", aclink_rx_pkg::ADDR_RX_SLOT1, e1);
    rd_chk("rx_slot2", aclink_rx_pkg::ADDR_RX_SLOT2, e2);
    check("rec_left", {16'h0, el}, {16'h0, rec_left_o});
    check("rec_right", {16'h0, er}, {16'h0, rec_right_o});
    check("rec_valid", nv, n_rv);
    check("play_req_left", npl, n_pl);
    check("play_req_right", npr, n_pr);
    $display("test frame tag %h done", tag);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    fail_count++;
    print_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    reg_sel_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 32'h0000_0000;
    reg_wdata_i = 32'h0000_0000;
    rows[0] = {aclink_rx_pkg::ADDR_REC_BASE, 32'h1000_0000, 32'h1000_0000};
    rows[1] = {aclink_rx_pkg::ADDR_REC_LEN, 32'h0000_0008, 32'h0000_0008};
    rows[2] = {aclink_rx_pkg::ADDR_PLAY_BASE, 32'h2000_0000, 32'h2000_0000};
    rows[3] = {aclink_rx_pkg::ADDR_PLAY_LEN, 32'h0000_000C, 32'h0000_000C};
    rows[4] = {aclink_rx_pkg::ADDR_REC_CUR, 32'hFFFF_FFFF, 32'h1000_0000};
    rows[5] = {aclink_rx_pkg::ADDR_PLAY_CUR, 32'hFFFF_FFFF, 32'h2000_0000};
    rows[6] = {aclink_rx_pkg::ADDR_RX_SLOT0, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[7] = {32'hFFF0_9048, 32'h1234_5678, 32'h0000_0000};
    rows[8] = {aclink_rx_pkg::ADDR_ACL_CTRL, 32'h0000_0000, 32'h0000_0000};
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    // ------------------------------------------------------------
    // Reset values of the whole map
    // ------------------------------------------------------------
    for (int i = 0; i < 18; i++) begin
      reg_op(1'b0, aclink_rx_pkg::ADDR_MAIN_CTRL + 32'(4 * i), 32'h0000_0000);
      check("reset value", (i == 9) ? aclink_rx_pkg::RST_PLAY_STAT : (i == 13) ?
            aclink_rx_pkg::RST_TX_SLOT1 : aclink_rx_pkg::RST_ZERO, rd);
    end
    $display("test reset values done");
    // ------------------------------------------------------------
    // Write then read back, read-only and unmapped places included
    // ------------------------------------------------------------
    foreach (rows[i]) begin
      reg_op(1'b1, rows[i].addr, rows[i].wdata);
      rd_chk("readback", rows[i].addr, rows[i].exp);
    end
    b2b(aclink_rx_pkg::ADDR_REC_LEN, 32'h0000_0030);
    b2b(aclink_rx_pkg::ADDR_REC_LEN, 32'h0000_0008);
    b2b(aclink_rx_pkg::ADDR_PLAY_LEN, 32'h0000_0030);
    b2b(aclink_rx_pkg::ADDR_PLAY_LEN, 32'h0000_000C);
    $display("test register rows done");
    // ------------------------------------------------------------
    // Frames: disabled link, enabled, variable rate, invalid frame
    // ------------------------------------------------------------
    frame(16'h8078, 20'h2_6000, 20'hA_BCD0, 20'h1_2340, 20'h5_6780, 32'h0, 32'h0, 32'h0,
          16'h0, 16'h0, 0, 0, 0);
    reg_op(1'b1, aclink_rx_pkg::ADDR_MAIN_CTRL, 32'h0000_0002);
    frame(16'h8078, 20'h2_6000, 20'hA_BCD0, 20'h1_2340, 20'h5_6780, 32'h0000_8078,
          32'h0002_6000, 32'h000A_BCD0, 16'h1234, 16'h5678, 1, 1, 1);
    rd_chk("rec_cur", aclink_rx_pkg::ADDR_REC_CUR, 32'h1000_0004);
    rd_chk("play_cur", aclink_rx_pkg::ADDR_PLAY_CUR, 32'h2000_0004);
    reg_op(1'b1, aclink_rx_pkg::ADDR_ACL_CTRL, 32'h0000_0001);
    frame(16'h8068, 20'h1_3800, 20'h0_0000, 20'h0_FED0, 20'h9_ABC0, 32'h0000_8068,
          32'h0001_3800, 32'h000A_BCD0, 16'h0FED, 16'h9ABC, 1, 1, 0);
    rd_chk("rec_cur wrap", aclink_rx_pkg::ADDR_REC_CUR, 32'h1000_0000);
    rd_chk("play_cur", aclink_rx_pkg::ADDR_PLAY_CUR, 32'h2000_0008);
    frame(16'h0078, 20'h7_F000, 20'h1_1110, 20'h2_2220, 20'h3_3330, 32'h0000_0078,
          32'h0001_3800, 32'h000A_BCD0, 16'h0FED, 16'h9ABC, 0, 0, 0);
    rd_chk("rec_cur", aclink_rx_pkg::ADDR_REC_CUR, 32'h1000_0000);
    // ------------------------------------------------------------
    // Reset in mid-run clears map, samples and link state
    // ------------------------------------------------------------
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd_chk("rec_base after reset", aclink_rx_pkg::ADDR_REC_BASE, 32'h0000_0000);
    rd_chk("rx_slot0 after reset", aclink_rx_pkg::ADDR_RX_SLOT0, 32'h0000_0000);
    check("rec_left after reset", 32'h0000_0000, {16'h0, rec_left_o});
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
